/* design/rcix_pkg.sv */
// Purpose: constants for the receive code interrupt status/enable block
// Assumes: plain register port, 16-bit byte address, 8-bit data
// Notes: enable register offset is arbitrary, placed next to status
//
// Functional notes
// - with its enable set, any change of the interworking state latches status bit 4.
// - latched change flags stay one until the status register is read, then clear.
// - enable bit 4 gates the interworking change interrupt, read/write, resets to zero.
// - enable bit 6 gates the auxiliary pattern change interrupt, read/write, resets to zero.
// - with its enable set, both start and end of aux pattern detection raise the interrupt.
// - status bit 6 is the aux pattern change flag, cleared on read, reset to zero.
// - status bit 7 shows live whether the aux pattern is being detected.
// - status bit 5 shows the interworking state declared by the alternate alignment search.
`default_nettype none

package rcix_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] STATUS_OFS = 16'h0b0a;
    localparam logic [15:0] ENABLE_OFS = 16'h0b0b;
    localparam int BIT_IW_FLAG = 4;
    localparam int BIT_IW_STATE = 5;
    localparam int BIT_AUX_FLAG = 6;
    localparam int BIT_AUX_LIVE = 7;
    localparam logic [7:0] ENABLE_MASK = 8'h50;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam int ALIGN_TIMEOUT_MS = 400;
endpackage : rcix_pkg

`default_nettype wire

/* design/rcix_irq.sv */
// Purpose: interrupt status and enable for interworking and aux pattern changes
// Assumes: state inputs synchronous to mclk; 400 ms search done upstream
// Notes: read data valid the cycle after the read strobe
`default_nettype none

module rcix_irq (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [rcix_pkg::ADDR_W-1:0] regAddr,
    input wire logic [rcix_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [rcix_pkg::DATA_W-1:0] regRdata,
    input wire logic alt_align_algo_en,
    input wire logic interwork_state,
    input wire logic aux_pattern_present,
    output logic irqOut
);
    import rcix_pkg::*;

    logic [DATA_W-1:0] enable_q;
    logic interwork_change_flag_q;
    logic aux_pattern_change_flag_q;
    logic iwState_q;
    logic auxLive_q;
    logic [DATA_W-1:0] rdata_q;
    logic irq_q;
    logic iwCur;
    logic iwChange;
    logic auxChange;
    logic statusRd;
    logic interwork_change_irq_en;
    logic aux_pattern_change_irq_en;

    // =========================================
    // event detection
    assign iwCur = interwork_state & alt_align_algo_en;
    assign iwChange = iwCur ^ iwState_q;
    assign auxChange = aux_pattern_present ^ auxLive_q;
    assign statusRd = regRd && (regAddr == STATUS_OFS);
    assign interwork_change_irq_en = enable_q[BIT_IW_FLAG];
    assign aux_pattern_change_irq_en = enable_q[BIT_AUX_FLAG];

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            iwState_q <= 1'b0;
            auxLive_q <= 1'b0;
        end
        else if (clkEn)
        begin
            iwState_q <= iwCur;
            auxLive_q <= aux_pattern_present;
        end
    end

    // =========================================
    // enable register
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            enable_q <= RESET_VAL;
        else if (clkEn && regWr && (regAddr == ENABLE_OFS))
            enable_q <= regWdata & ENABLE_MASK;
    end

    // =========================================
    // sticky flags; a new event wins over the clearing read
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            interwork_change_flag_q <= 1'b0;
        else if (clkEn)
        begin
            if (iwChange && interwork_change_irq_en)
                interwork_change_flag_q <= 1'b1;
            else if (statusRd)
                interwork_change_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            aux_pattern_change_flag_q <= 1'b0;
        else if (clkEn)
        begin
            if (auxChange && aux_pattern_change_irq_en)
                aux_pattern_change_flag_q <= 1'b1;
            else if (statusRd)
                aux_pattern_change_flag_q <= 1'b0;
        end
    end

    // =========================================
    // read path
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            rdata_q <= RESET_VAL;
        else if (clkEn)
        begin
            rdata_q <= RESET_VAL;
            if (regRd && (regAddr == STATUS_OFS))
            begin
                rdata_q[BIT_AUX_LIVE] <= auxLive_q;
                rdata_q[BIT_AUX_FLAG] <= aux_pattern_change_flag_q;
                rdata_q[BIT_IW_STATE] <= iwState_q;
                rdata_q[BIT_IW_FLAG] <= interwork_change_flag_q;
            end
            else if (regRd && (regAddr == ENABLE_OFS))
                rdata_q <= enable_q;
        end
    end

    // flags only set when enabled, yet each flag is gated by its enable bit here as well
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            irq_q <= 1'b0;
        else if (clkEn)
            irq_q <= (interwork_change_flag_q & interwork_change_irq_en)
                   | (aux_pattern_change_flag_q & aux_pattern_change_irq_en);
    end

    assign regRdata = rdata_q;
    assign irqOut = irq_q;
endmodule : rcix_irq

`default_nettype wire

/* verif/rcix_checker.sv */
// Purpose: port assertions for rcix_irq
// Assumes: clkEn held high while checked
// Notes: bound to every rcix_irq below
`default_nettype none
module rcix_checker (
    input wire logic mclk, sys_rst, regWr, regRd, irqOut,
    input wire logic alt_align_algo_en, interwork_state, aux_pattern_present,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regRdata
);
    import rcix_pkg::*;
    wire logic rdS = regRd && regAddr == STATUS_OFS;
    wire logic rdE = regRd && regAddr == ENABLE_OFS;
    wire logic iwG = interwork_state && alt_align_algo_en;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // no input change and no write, so flags can only be cleared
    sequence quiet; $stable(aux_pattern_present) && $stable(iwG) && !regWr; endsequence
    sequence quietRd; quiet ##0 rdS; endsequence
    idle_rd_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data outside read slot");
    rsvd_lo_a: assert property ($past(regRd) |-> regRdata[3:0] == 4'h0)
        else $error("low bits not zero");
    live_aux_a: assert property ($past(rdS) |-> regRdata[7] == $past(aux_pattern_present, 2))
        else $error("live pattern bit wrong");
    iw_state_a: assert property ($past(rdS) |-> regRdata[5] == $past(iwG, 2))
        else $error("interwork state bit wrong");
    en_rsvd_a: assert property ($past(rdE) |-> (regRdata & 8'haf) == 8'h00)
        else $error("enable reads stray bits");
    irq_drop_a: assert property (quiet [*2] ##1 quietRd |-> ##2 !irqOut)
        else $error("interrupt held after read");
    irq_still_a: assert property (quiet [*3] ##0 !irqOut |-> ##1 !irqOut)
        else $error("interrupt without event");
    flag_clear_a: assert property (quietRd ##1 quiet ##1 quietRd |-> ##1 !regRdata[6] && !regRdata[4])
        else $error("flag survived read");
endmodule : rcix_checker
bind rcix_irq rcix_checker chk (.mclk, .sys_rst, .regWr, .regRd, .irqOut, .alt_align_algo_en,
    .interwork_state, .aux_pattern_present, .regAddr, .regRdata);
`default_nettype wire

/* verif/e1_rx_interwork_aux_irq_tb_top.sv */
// Purpose: self-checking bench for rcix_irq
// Assumes: clkEn high except while freeze_test holds it low
// Notes: flags seen through status reads
`default_nettype none
module e1_rx_interwork_aux_irq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rcix_pkg::*;
    logic mclk = 0, sys_rst = 1, regWr = 0, regRd = 0, irqOut;
    logic algoEn = 0, iwState = 0, auxPresent = 0, clkEn = 1;
    logic [15:0] regAddr = 0;
    logic [7:0] regWdata = 0, regRdata;
    int err_count = 0, check_count = 0;
    initial forever #2.5 mclk = ~mclk;
    rcix_irq dut (.mclk, .sys_rst, .clkEn, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .alt_align_algo_en(algoEn), .interwork_state(iwState),
        .aux_pattern_present(auxPresent), .irqOut);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk
    // one strobe cycle; read data is looked at only in the slot after it
    task automatic acc(input logic wrNow, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        {regWr, regRd, regAddr, regWdata} <= {wrNow, !wrNow, a, d};
        @(posedge mclk);
        {regWr, regRd} <= 2'b00;
        #1 if (!wrNow) chk(regRdata, d);
    endtask : acc
    task automatic ev(input logic [2:0] v, input logic irqExp);
        @(posedge mclk);
        {algoEn, iwState, auxPresent} <= v;
        repeat (3) @(posedge mclk);
        #1 chk(irqOut, irqExp);
    endtask : ev
    task automatic reg_test;
        acc(0, STATUS_OFS, 8'h00);
        acc(0, ENABLE_OFS, 8'h00);
        acc(1, ENABLE_OFS, 8'hff);
        acc(1, STATUS_OFS, 8'hff);
        acc(0, ENABLE_OFS, 8'h50);
        acc(0, 16'h0b0c, 8'h00);
    endtask : reg_test
    task automatic event_test;
        ev(3'b001, 1);
        acc(0, STATUS_OFS, 8'hc0);
        acc(0, STATUS_OFS, 8'h80);
        ev(3'b110, 1);
        acc(0, STATUS_OFS, 8'h70);
        acc(1, ENABLE_OFS, 8'h00);
        ev(3'b100, 0);
        acc(0, STATUS_OFS, 8'h00);
    endtask : event_test
    // a write while the clock enable is low must leave the enable register alone
    task automatic freeze_test;
        @(posedge mclk);
        clkEn <= 0;
        acc(1, ENABLE_OFS, 8'h50);
        @(posedge mclk);
        clkEn <= 1;
        acc(0, ENABLE_OFS, 8'h00);
    endtask : freeze_test
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (2) @(posedge mclk);
        sys_rst <= 0;
        reg_test;
        event_test;
        freeze_test;
        close_out;
    end
    initial
    begin
        #2000 err_count++;
        close_out;
    end
endmodule : e1_rx_interwork_aux_irq_tb_top
`default_nettype wire
